// ---- hw/apsram_pkg.sv ----
// Package of timing constants, states and carrier structs for the pseudo-static RAM host controller.
package apsram_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // Least times round up, longest times round down.
    function automatic int cyclesMin(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    function automatic int cyclesMax(input int ns);
        int c;
        c = ns / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int POWER_UP_WAIT_US = 150;
    localparam int SELECT_PULSE_LIMIT_US = 8;
    localparam int ADDR_TO_WRITE_END_NS = 70;
    localparam int WRITE_CYCLE_NS = 70;
    localparam int WRITE_LOW_WIDTH_NS = 46;
    localparam int WRITE_HIGH_WIDTH_NS = 10;
    localparam int WRITE_DATA_SETUP_NS = 23;
    localparam int LANE_TO_WRITE_END_NS = 70;
    localparam int SELECT_HIGH_NS = 5;
    localparam int READ_ACCESS_NS = 70;
    localparam int OUTPUT_ENABLE_ACCESS_NS = 20;
    localparam int CFG_WRITE_LOW_WIDTH_NS = 40;
    localparam int SLEEP_TO_WRITE_DELAY_MIN_NS = 10;
    localparam int SLEEP_TO_WRITE_DELAY_MAX_NS = 500;
    localparam int DESELECT_TO_SLEEP_DELAY_NS = 5;
    localparam int DEEP_SLEEP_MIN_US = 10;
    localparam int DEEP_SLEEP_RECOVERY_US = 150;
    localparam int NS_PER_US = 1000;
    localparam int SELECT_PULSE_LIMIT_CYC = cyclesMax(SELECT_PULSE_LIMIT_US * NS_PER_US);
    localparam int WRITE_LOW_CYC = cyclesMin(WRITE_LOW_WIDTH_NS) >
        cyclesMin(ADDR_TO_WRITE_END_NS) ? cyclesMin(WRITE_LOW_WIDTH_NS) :
        cyclesMin(ADDR_TO_WRITE_END_NS);
    localparam int WRITE_HIGH_CYC = cyclesMin(WRITE_HIGH_WIDTH_NS) >
        cyclesMin(SELECT_HIGH_NS) ? cyclesMin(WRITE_HIGH_WIDTH_NS) : cyclesMin(SELECT_HIGH_NS);
    localparam int READ_ACCESS_CYC = cyclesMin(READ_ACCESS_NS) + 1;
    localparam int CFG_WRITE_LOW_CYC = WRITE_LOW_CYC;
    localparam int SLEEP_TO_WRITE_CYC = cyclesMin(SLEEP_TO_WRITE_DELAY_MIN_NS);
    localparam int SLEEP_TO_WRITE_MAX_CYC = cyclesMax(SLEEP_TO_WRITE_DELAY_MAX_NS);
    localparam int DESELECT_TO_SLEEP_CYC = cyclesMin(DESELECT_TO_SLEEP_DELAY_NS);
    localparam int ADDR_W = 21;
    localparam int DATA_W = 16;
    localparam int CNT_W = 18;
    typedef enum logic [3:0] {
        ST_POWER_UP = 4'h0,
        ST_IDLE = 4'h1,
        ST_READ = 4'h2,
        ST_WRITE = 4'h3,
        ST_RECOVER = 4'h4,
        ST_CFG_DESEL = 4'h5,
        ST_CFG_SETUP = 4'h6,
        ST_CFG_WRITE = 4'h7,
        ST_DPD_DESEL = 4'h8,
        ST_DPD_HOLD = 4'h9,
        ST_DPD_RECOVER = 4'ha
    } apsram_state_t;
    typedef enum logic [2:0] {
        CMD_READ = 3'h0,
        CMD_WRITE = 3'h1,
        CMD_LOAD_CONFIG = 3'h2,
        CMD_DEEP_SLEEP = 3'h3
    } apsram_cmd_t;
    // Request from the user side.
    typedef struct packed {
        apsram_cmd_t cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] laneEnable;
    } apsram_req_t;
    // Memory pins, strobes active low.
    typedef struct packed {
        logic selectLow;
        logic writeLow;
        logic outputLow;
        logic [1:0] byteLaneSelectsLow;
        logic sleepControlLow;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dqOut;
        logic dqOutEnableLow;
    } apsram_pins_t;
    // Whole controller state.
    typedef struct packed {
        apsram_state_t state;
        logic [CNT_W-1:0] count;
        apsram_pins_t pins;
        logic [DATA_W-1:0] rdata;
        logic rvalid;
        logic done;
    } apsram_regs_t;
endpackage

// ---- hw/apsram_host_ctrl.sv ----
// Host-side controller that sequences reads, writes, configuration loads and deep sleep.
// Operation
// RL1: Wait 150 us after power-up before access.
// RL2: Chip select pulse never exceeds 8 us.
// RL3: Write strobe low never exceeds 8 us.
// RL4: Address held 70 ns; writes 70 ns apart.
// RL5: Write low 46 ns, high 10 ns.
// RL6: Write data valid 23 ns before end.
// RL7: Lanes and select asserted 70 ns before end.
// RL8: Select high 5 ns between writes.
// RL9: Memory read data valid 70 ns after select.
// RL10: Memory data valid 20 ns after output strobe.
// RL11: Memory holds old data 5 ns.
// RL12: Config load: sleep low 10-500 ns first.
// RL13: Deselect 5 ns before sleep pin low.
// RL14: Deep sleep 10 us low, 150 us recovery.
// RL15: Minimums round up, maximums round down; the microsecond wait parameters divide and round down instead.
module apsram_host_ctrl
    import apsram_pkg::*;
#(
    parameter int POWER_UP_CYC = (POWER_UP_WAIT_US * NS_PER_US) / CLK_PERIOD_NS,
    parameter int DEEP_SLEEP_CYC = (DEEP_SLEEP_MIN_US * NS_PER_US) / CLK_PERIOD_NS,
    parameter int RECOVERY_CYC = (DEEP_SLEEP_RECOVERY_US * NS_PER_US) / CLK_PERIOD_NS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic reqValid,
    input apsram_req_t req,
    output logic reqReady,
    output logic [DATA_W-1:0] rdata,
    output logic rvalid,
    output logic done,
    output apsram_pins_t pins,
    input wire logic [DATA_W-1:0] dqIn
);
    apsram_regs_t r;
    apsram_regs_t next_r;

    // Every phase is a whole number of clock periods, derived from the clock period in the package or, for
    // the microsecond waits, in the parameters above. Package minimums round up and limits round down, so a phase
    // may run slightly longer than the memory needs; that costs a little bandwidth on each access but can never
    // break a minimum, while the parameters divide and round down. A different clock only changes CLK_PERIOD_NS.

    // Count load helper: a phase of c cycles loads c - 1 and ends when the count is zero.
    // The value is truncated on purpose to the counter width.
    function automatic logic [CNT_W-1:0] toCount(input int c);
        return CNT_W'(c - 1);
    endfunction

    // Strobes, lanes and the data drive go inactive together; only the address stays, so the memory
    // still sees it settled at the strobe's rising edge, where no hold time is left.
    function automatic apsram_pins_t releaseStrobes(input apsram_pins_t p);
        apsram_pins_t q;
        q = p;
        q.selectLow = 1'b1;
        q.writeLow = 1'b1;
        q.outputLow = 1'b1;
        q.byteLaneSelectsLow = 2'h3;
        q.sleepControlLow = 1'b1;
        q.dqOutEnableLow = 1'b1;
        return q;
    endfunction

    // Pins at rest: every strobe inactive and the data bus left to the memory.
    localparam apsram_pins_t PINS_IDLE = '{selectLow: 1'b1, writeLow: 1'b1, outputLow: 1'b1,
        byteLaneSelectsLow: 2'h3, sleepControlLow: 1'b1, addr: '0, dqOut: '0,
        dqOutEnableLow: 1'b1};

    // The handshake is combinational from the state; data and pins come from flip-flops.
    assign reqReady = (r.state == ST_IDLE);
    assign pins = r.pins;
    assign rdata = r.rdata;
    assign rvalid = r.rvalid;
    assign done = r.done;

    // Next-state logic; every timed phase counts down to zero before it moves on.
    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        next_r.done = 1'b0;
        if (r.count != '0) begin
            next_r.count = r.count - 1'b1;
        end
        case (r.state)
            // Hold every strobe inactive until the start-up wait has run out.
            ST_POWER_UP: begin
                if (r.count == '0) begin // RL1
                    next_r.state = ST_IDLE;
                end
            end

            // Idle: the address is captured with the request, valid from the first cycle.
            ST_IDLE: begin
                next_r.pins = PINS_IDLE;
                if (reqValid) begin
                    next_r.pins.addr = req.addr; // RL4
                    case (req.cmd)
                        // Select, output strobe and lanes go low together with the address.
                        CMD_READ: begin
                            next_r.pins.selectLow = 1'b0;
                            next_r.pins.outputLow = 1'b0;
                            next_r.pins.byteLaneSelectsLow = ~req.laneEnable;
                            next_r.count = toCount(READ_ACCESS_CYC); // RL9 RL10
                            next_r.state = ST_READ;
                        end
                        // Strobe, select, lanes and data all start in the same cycle.
                        CMD_WRITE: begin
                            next_r.pins.selectLow = 1'b0; // RL7
                            next_r.pins.writeLow = 1'b0;
                            next_r.pins.byteLaneSelectsLow = ~req.laneEnable; // RL7
                            next_r.pins.dqOut = req.wdata; // RL6
                            next_r.pins.dqOutEnableLow = 1'b0;
                            next_r.count = toCount(WRITE_LOW_CYC); // RL5 RL15
                            next_r.state = ST_WRITE;
                        end
                        // Select is already high in idle; the wait still covers deselect.
                        CMD_LOAD_CONFIG: begin
                            next_r.count = toCount(DESELECT_TO_SLEEP_CYC); // RL13
                            next_r.state = ST_CFG_DESEL;
                        end
                        // Deep sleep first spends the deselect time with every strobe high.
                        CMD_DEEP_SLEEP: begin
                            next_r.count = toCount(DESELECT_TO_SLEEP_CYC); // RL13
                            next_r.state = ST_DPD_DESEL;
                        end
                        default: begin
                            next_r.pins = PINS_IDLE;
                        end
                    endcase
                end
            end

            // Read: wait out the access time, then capture the bus.
            ST_READ: begin
                // Sampling one cycle after the access time leaves margin for the data path.
                if (r.count == '0) begin
                    next_r.rdata = dqIn;
                    next_r.rvalid = 1'b1;
                    next_r.pins = releaseStrobes(r.pins); // RL11
                    next_r.count = toCount(WRITE_HIGH_CYC);
                    next_r.state = ST_RECOVER;
                end
            end

            // Data writes and configuration loads end the same way.
            ST_WRITE, ST_CFG_WRITE: begin
                // Select, strobe, lanes and data end together, so only the address outlives setup.
                if (r.count == '0) begin // RL2 RL3
                    next_r.pins = releaseStrobes(r.pins); // RL6 RL8
                    next_r.done = 1'b1;
                    next_r.count = toCount(WRITE_HIGH_CYC); // RL5 RL8
                    next_r.state = ST_RECOVER;
                end
            end

            // One cycle with every strobe high keeps writes and selects apart.
            ST_RECOVER: begin
                if (r.count == '0) begin // RL4
                    next_r.state = ST_IDLE;
                end
            end

            // The sleep pin goes low only after the deselect time.
            ST_CFG_DESEL: begin
                if (r.count == '0) begin
                    next_r.pins.sleepControlLow = 1'b0; // RL13
                    next_r.count = toCount(SLEEP_TO_WRITE_CYC); // RL12
                    next_r.state = ST_CFG_SETUP;
                end
            end

            // The configuration strobe waits the least sleep-to-write time.
            ST_CFG_SETUP: begin
                // Strobe goes low well inside the 500 ns ceiling.
                if (r.count == '0) begin // RL12
                    next_r.pins.selectLow = 1'b0;
                    next_r.pins.writeLow = 1'b0;
                    next_r.count = toCount(CFG_WRITE_LOW_CYC); // RL12
                    next_r.state = ST_CFG_WRITE;
                end
            end

            // Deep sleep entry mirrors the configuration deselect.
            ST_DPD_DESEL: begin
                if (r.count == '0) begin
                    next_r.pins.sleepControlLow = 1'b0; // RL13
                    next_r.count = toCount(DEEP_SLEEP_CYC); // RL14
                    next_r.state = ST_DPD_HOLD;
                end
            end

            // The sleep pin stays low for the least deep-sleep time.
            ST_DPD_HOLD: begin
                if (r.count == '0) begin
                    next_r.pins.sleepControlLow = 1'b1;
                    next_r.count = toCount(RECOVERY_CYC); // RL14
                    next_r.state = ST_DPD_RECOVER;
                end
            end

            // No access until the memory has recovered from deep sleep.
            ST_DPD_RECOVER: begin
                if (r.count == '0) begin // RL14
                    next_r.done = 1'b1;
                    next_r.state = ST_IDLE;
                end
            end

            // An illegal state falls back to idle with the pins at rest.
            default: begin
                next_r.state = ST_IDLE;
                next_r.pins = PINS_IDLE;
            end
        endcase
    end

    // State register; reset starts the power-up wait with all strobes inactive.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= '{state: ST_POWER_UP, count: CNT_W'(POWER_UP_CYC - 1), pins: PINS_IDLE,
                rdata: '0, rvalid: 1'b0, done: 1'b0};
        end else if (clkEnable) begin
            r <= next_r;
        end
    end
endmodule

// ---- sim/apsram_mem_model.sv ----
// Behavioural pseudo-static RAM that answers the host controller's pins.
module apsram_mem_model
    import apsram_pkg::*;
(
    input wire logic clk,
    input apsram_pins_t pins,
    output logic [DATA_W-1:0] dqIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [DATA_W-1:0] mem [16];
    logic [DATA_W-1:0] last = 16'h0;
    apsram_pins_t prev = '1;
    int accCnt = 0;
    // Data shows only after the full access time, as late as allowed; a released bus toggles.
    assign dqIn = (!pins.selectLow && !pins.outputLow && accCnt >= 7) ?
        mem[pins.addr[3:0]] : ~last;
    // A write lands at the strobe's rising edge; only 16 words exist, upper address is ignored.
    always @(posedge clk) begin
        last <= dqIn;
        prev <= pins;
        accCnt <= (!pins.selectLow && !pins.outputLow) ? accCnt + 1 : 0;
        if (!prev.writeLow && pins.writeLow && prev.sleepControlLow) begin
            if (!prev.byteLaneSelectsLow[0])
                mem[prev.addr[3:0]][7:0] <= prev.dqOut[7:0];
            if (!prev.byteLaneSelectsLow[1])
                mem[prev.addr[3:0]][15:8] <= prev.dqOut[15:8];
        end
    end
endmodule

// ---- sim/apsram_host_ctrl_props.sv ----
// Checker of pin timing for the pseudo-static RAM host controller.
module apsram_host_ctrl_props
    import apsram_pkg::*;
#(
    parameter int POWER_UP_CYC = 20,
    parameter int DEEP_SLEEP_CYC = 5,
    parameter int RECOVERY_CYC = 20
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clkEnable,
    input wire logic reqValid,
    input apsram_req_t req,
    input wire logic reqReady,
    input apsram_pins_t pins
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    int upCnt;
    int selCnt;
    int sleepCnt;
    int wakeCnt;
    apsram_cmd_t lastCmd;
    // Pulse counters; upCnt saturates so a long run cannot wrap it.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            upCnt <= 0;
            selCnt <= 0;
            sleepCnt <= 0;
            wakeCnt <= 1000000;
            lastCmd <= CMD_READ;
        end else begin
            upCnt <= (upCnt < 1000000) ? upCnt + 1 : upCnt;
            selCnt <= pins.selectLow ? 0 : selCnt + 1;
            sleepCnt <= pins.sleepControlLow ? 0 : sleepCnt + 1;
            // Cycles since a deep sleep ended; a configuration load does not restart it.
            if (!pins.sleepControlLow && lastCmd == CMD_DEEP_SLEEP)
                wakeCnt <= 0;
            else if (wakeCnt < 1000000)
                wakeCnt <= wakeCnt + 1;
            if (clkEnable && reqValid && reqReady)
                lastCmd <= req.cmd;
        end
    end
    up_wait_a: assert property (!pins.selectLow |-> upCnt >= POWER_UP_CYC)
        else $error("select before start-up wait");
    sel_limit_a: assert property (selCnt < SELECT_PULSE_LIMIT_CYC)
        else $error("select pulse too long");
    wr_width_a: assert property ($fell(pins.writeLow) |->
        (!pins.writeLow && !pins.selectLow)[*7] ##1 pins.writeLow)
        else $error("write pulse width wrong");
    wr_data_a: assert property ($fell(pins.writeLow) && pins.sleepControlLow |->
        ##1 (!pins.dqOutEnableLow && $stable(pins.dqOut) && $stable(pins.addr))[*6])
        else $error("write data or address moved");
    sel_gap_a: assert property ($rose(pins.selectLow) |=> pins.selectLow)
        else $error("select high gap too short");
    desel_sleep_a: assert property ($fell(pins.sleepControlLow) |->
        pins.selectLow && $past(pins.selectLow)) else $error("sleep low while selected");
    cfg_write_a: assert property ($fell(pins.writeLow) && !pins.sleepControlLow |->
        sleepCnt >= SLEEP_TO_WRITE_CYC && sleepCnt <= SLEEP_TO_WRITE_MAX_CYC)
        else $error("sleep to write delay wrong");
    dpd_hold_a: assert property ($rose(pins.sleepControlLow) &&
        lastCmd == CMD_DEEP_SLEEP |-> sleepCnt >= DEEP_SLEEP_CYC)
        else $error("deep sleep too short");
    dpd_recover_a: assert property (!pins.selectLow |-> wakeCnt >= RECOVERY_CYC)
        else $error("select during deep sleep recovery");
endmodule
bind apsram_host_ctrl apsram_host_ctrl_props #(.POWER_UP_CYC(POWER_UP_CYC),
    .DEEP_SLEEP_CYC(DEEP_SLEEP_CYC), .RECOVERY_CYC(RECOVERY_CYC)) props_u (.clk(clk),
    .reset_n(reset_n), .clkEnable(clkEnable), .reqValid(reqValid), .req(req),
    .reqReady(reqReady), .pins(pins));

// ---- sim/tb_apsram_host_ctrl.sv ----
// Testbench of the host controller against a behavioural memory.
module tb_apsram_host_ctrl
    import apsram_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clkEnable = 1'b1;
    logic reqValid = 1'b0;
    apsram_req_t req = '0;
    logic reqReady;
    logic rvalid;
    logic done;
    logic [DATA_W-1:0] rdata;
    logic [DATA_W-1:0] dqIn;
    apsram_pins_t pins;
    int mismatches = 0;
    int total_checks = 0;
    int cyc;
    // Half-period toggle gives the 100 MHz clock.
    always #5 clk = ~clk;
    apsram_host_ctrl #(.POWER_UP_CYC(20), .DEEP_SLEEP_CYC(5), .RECOVERY_CYC(20)) dut_u (
        .clk(clk), .reset_n(reset_n), .clkEnable(clkEnable), .reqValid(reqValid), .req(req),
        .reqReady(reqReady), .rdata(rdata), .rvalid(rvalid), .done(done), .pins(pins),
        .dqIn(dqIn));
    apsram_mem_model mem_u (.clk(clk), .pins(pins), .dqIn(dqIn));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Sends one request when ready; cyc counts edges from acceptance to the answer pulse.
    task automatic issue(input apsram_cmd_t cmd, input logic [20:0] addr,
        input logic [15:0] data, input logic [1:0] lanes, input int stall);
        int n;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        reqValid = 1'b1;
        req = '{cmd, addr, data, lanes};
        @(posedge clk);
        #1;
        reqValid = 1'b0;
        if (stall > 0) begin
            clkEnable = 1'b0;
            repeat (stall) @(posedge clk);
            #1;
            clkEnable = 1'b1;
        end
        cyc = stall;
        do begin
            @(posedge clk);
            #1;
            cyc++;
        end while (rvalid !== 1'b1 && done !== 1'b1 && cyc < 200);
        // A request that never gets its turn or its answer counts as a mismatch.
        if (n >= 100 || cyc >= 200) begin
            mismatches++;
            $display("[FAIL] %0t ns: request timed out", $time);
        end
    endtask
    // Nothing may be accepted before the start-up wait has run out.
    task automatic power_up_test();
        int n;
        n = 0;
        check(32'(reqReady), 32'h0);
        while (reqReady !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(n, 32'h14);
    endtask
    // Back-to-back writes, one on the low lane only, then reads timed by the slowest memory.
    task automatic write_read_test();
        issue(CMD_WRITE, 21'h3, 16'ha5c3, 2'h3, 0);
        check(cyc, 32'h7);
        issue(CMD_WRITE, 21'h4, 16'h1234, 2'h3, 0);
        issue(CMD_WRITE, 21'h3, 16'hffee, 2'h1, 0);
        check(cyc, 32'h7);
        issue(CMD_READ, 21'h3, 16'h0, 2'h3, 0);
        check(cyc, 32'h8);
        check(32'(rdata), 32'ha5ee);
        issue(CMD_READ, 21'h4, 16'h0, 2'h3, 0);
        check(32'(rdata), 32'h1234);
    endtask
    // A configuration load must not disturb the array.
    task automatic config_test();
        issue(CMD_LOAD_CONFIG, 21'h10, 16'h0, 2'h3, 0);
        check(cyc, 32'h9);
        issue(CMD_READ, 21'h4, 16'h0, 2'h3, 0);
        check(32'(rdata), 32'h1234);
    endtask
    // Deep sleep with a clock-enable stall of three cycles, then a normal read.
    task automatic deep_sleep_test();
        issue(CMD_DEEP_SLEEP, 21'h0, 16'h0, 2'h3, 3);
        check(cyc, 32'h1d);
        issue(CMD_READ, 21'h3, 16'h0, 2'h3, 0);
        check(cyc, 32'h8);
    endtask
    // Main sequence after twelve cycles of reset.
    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        power_up_test();
        write_read_test();
        config_test();
        deep_sleep_test();
        report_and_stop();
    end
    // Watchdog: the sequence needs well under a thousand cycles.
    initial begin
        #20000;
        mismatches++;
        report_and_stop();
    end
endmodule
